// ==== design/adc_readout_pkg.sv ====
// Shared constants and types for the dual-channel converter readout block
package adc_readout_pkg;

   // ----------------------------------------------------------------------
   // Result format
   // ----------------------------------------------------------------------
   localparam int RESULT_BITS = 16;        // Bits per channel result
   localparam int FIFO_DEPTH = 16;         // Words buffered ahead of readout
   localparam int BIT_CNT_W = 5;           // Wide enough to hold RESULT_BITS
   localparam logic [BIT_CNT_W-1:0] BITS_PER_RESULT = 5'h10;
   localparam logic [BIT_CNT_W-1:0] BITS_NONE = 5'h00;
   localparam logic [BIT_CNT_W-1:0] BIT_STEP = 5'h01;

   // ----------------------------------------------------------------------
   // Strobe pulse counts that step the power states (serial clock static)
   // ----------------------------------------------------------------------
   localparam logic [2:0] PULSES_NONE = 3'h0;
   localparam logic [2:0] PULSE_STEP = 3'h1;
   localparam logic [2:0] PULSES_TO_NAP = 3'h2;
   localparam logic [2:0] PULSES_TO_SLEEP = 3'h4;
   localparam logic [2:0] PULSES_TO_WAKE = 3'h5;

   // ----------------------------------------------------------------------
   // Power states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      PWR_OPER,
      PWR_NAP,
      PWR_SLEEP
   } power_state_t;

endpackage : adc_readout_pkg

// ==== design/sample_fifo.sv ====
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
      logic [AW:0] wr;                  // Write pointer with wrap bit
      logic [AW:0] rd;                  // Read pointer with wrap bit
   } fifo_state_t;

   fifo_state_t q, d;
   logic full;
   logic empty;

   // Wrap bits differ and index bits match only when every slot is used
   assign full = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
   assign empty = (q.wr == q.rd);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = q.mem[q.rd[AW-1:0]];

   // Next state: write and read may happen in the same cycle
   always_comb begin
      d = q;
      if (in_valid && !full) begin
         d.mem[q.wr[AW-1:0]] = in_data;
         d.wr = q.wr + 1'b1;
      end
      if (out_ready && !empty) begin
         d.rd = q.rd + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : sample_fifo

// ==== design/adc_serial_readout.sv ====
// Conversion control, two-lane serial readout and nap/sleep logic
//
// How it works
// - Strobe rise samples, strobe fall starts conversion
// - Conversion timing is set by the strobe, independent of the serial clock
// - Serial clock falling edge shifts next bit, MSB first
// - Echoed clock follows data with matched timing
// - Negative echo leg tied high disables echo output in CMOS mode only
// - Two strobe pulses, clock static, enter nap
// - Nap holds until serial clock rise or pulses
// - Two more pulses while napping enter sleep
// - CMOS mode: serial clock rise leaves sleep
// - Fifth strobe pulse leaves sleep; clock keeps awake
// - Strobe pulses alone cycle operate, nap, sleep
// - Select input chooses CMOS or LVDS lanes
// - CMOS drives positive legs only, negatives low
// - LVDS drives and receives differential pairs
// - One conversion latency; first burst result flagged stale
`timescale 1ns/1ps
module adc_serial_readout
   import adc_readout_pkg::*;
#(
   parameter int WORD_BITS = RESULT_BITS,
   parameter int BUF_DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pins from the host: conversion strobe and serial clock pair
   input wire logic convert_strobe,
   input wire logic serial_clk_p,
   input wire logic serial_clk_n,
   // Configuration pins
   input wire logic lvds_select,
   input wire logic echo_n_tied,
   // Results from the converter core
   input wire logic [WORD_BITS-1:0] sample_ch1,
   input wire logic [WORD_BITS-1:0] sample_ch2,
   input wire logic sample_valid,
   output logic sample_ready,
   // Serial data and echoed clock pairs
   output logic channel_one_serial_out_p,
   output logic channel_one_serial_out_n,
   output logic channel_two_serial_out_p,
   output logic channel_two_serial_out_n,
   output logic echoed_capture_clock_p,
   output logic echoed_capture_clock_n,
   // Status
   output logic nap_active,
   output logic sleep_active,
   output logic result_stale,
   output logic readout_busy
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   // Serial clock level: positive leg alone in CMOS, pair sign in LVDS
   // Equal legs read low, so an idle pair makes no edge
   function automatic logic link_level(input logic p, input logic n, input logic diff);
      return diff ? (p & ~n) : p;
   endfunction : link_level

   // Shift a result one place toward the MSB end
   // Zero enters at the LSB, so lanes idle low after a word
   function automatic logic [WORD_BITS-1:0] shift_up(input logic [WORD_BITS-1:0] w);
      return {w[WORD_BITS-2:0], 1'b0};
   endfunction : shift_up

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] strobe_s;              // Strobe synchroniser
      logic [1:0] sckp_s;                // Serial clock positive leg sync
      logic [1:0] sckn_s;                // Serial clock negative leg sync
      logic [1:0] sel_s;                 // Interface select sync
      logic [1:0] tie_s;                 // Echo tie sense sync
      logic strobe_prev;                 // Strobe level one cycle back
      logic sck_prev;                    // Serial clock level one cycle back
      power_state_t pstate;              // Power state
      logic [2:0] pulses;                // Strobe rises since last clock rise
      logic [BIT_CNT_W-1:0] bits_left;   // Falling edges still to shift
      logic [WORD_BITS-1:0] shift1;      // Channel one output shifter
      logic [WORD_BITS-1:0] shift2;      // Channel two output shifter
      logic [WORD_BITS-1:0] held1;       // Channel one result in conversion
      logic [WORD_BITS-1:0] held2;       // Channel two result in conversion
      logic stale;                       // Next loaded result is invalid
      logic out_stale;                   // Result now shifting is invalid
      logic echo;                        // Echoed clock level
   } readout_state_t;

   readout_state_t q, d;

   // Derived signals
   // Plain decodes of registered state; no pin is read here
   logic lvds;            // LVDS interface selected
   logic echo_off;        // Echo positive leg disabled
   logic sck_level;       // Decoded serial clock level
   logic sck_rise;        // Serial clock rising edge seen
   logic sck_fall;        // Serial clock falling edge seen
   logic strobe_rise;     // Strobe rising edge seen
   logic strobe_fall;     // Strobe falling edge seen
   logic conv_start;      // Conversion starts this cycle
   logic [2:0] pulse_next; // Strobe count after this rise
   logic fifo_valid;      // Buffered result available
   logic fifo_pop;        // Take buffered result
   logic [2*WORD_BITS-1:0] fifo_word; // Buffered pair, channel one high

   // ----------------------------------------------------------------------
   // Result buffer
   // ----------------------------------------------------------------------
   // Core results wait here; when full, sample_ready drops and stalls core
   // One pair is popped per conversion start, never otherwise
   // Sixteen pairs ride out a pause in the host clock
   sample_fifo #(
      .WIDTH(2 * WORD_BITS),
      .DEPTH(BUF_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_data({sample_ch1, sample_ch2}),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .out_data(fifo_word),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   // ----------------------------------------------------------------------
   // Edge detection on synchronised pins
   // ----------------------------------------------------------------------
   // Only second-stage flops are read; first stages feed nothing else
   // A pin edge acts three cycles late, so each pin level
   // must stand at least four system clock cycles
   assign lvds = q.sel_s[1];
   assign echo_off = q.tie_s[1] & ~lvds;
   assign sck_level = link_level(q.sckp_s[1], q.sckn_s[1], lvds);
   assign sck_rise = sck_level & ~q.sck_prev;
   assign sck_fall = ~sck_level & q.sck_prev;
   assign strobe_rise = q.strobe_s[1] & ~q.strobe_prev;
   assign strobe_fall = ~q.strobe_s[1] & q.strobe_prev;
   assign pulse_next = q.pulses + PULSE_STEP;
   assign conv_start = strobe_fall && (q.pstate == PWR_OPER);
   assign fifo_pop = conv_start && fifo_valid;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      d = q;
      // Two-flop synchronisers for every pin
      d.strobe_s = {q.strobe_s[0], convert_strobe};
      d.sckp_s = {q.sckp_s[0], serial_clk_p};
      d.sckn_s = {q.sckn_s[0], serial_clk_n};
      d.sel_s = {q.sel_s[0], lvds_select};
      d.tie_s = {q.tie_s[0], echo_n_tied};
      d.strobe_prev = q.strobe_s[1];
      d.sck_prev = sck_level;

      // Power state: a clock rise beats a strobe rise in the same cycle
      // Rises count only while the clock is quiet, so a
      // host that keeps clocking never drifts into nap
      if (sck_rise) begin
         if (q.pstate == PWR_SLEEP && lvds) begin
            // LVDS sleep ignores the clock; only the fifth pulse wakes
            d.pulses = q.pulses;
         end else begin
            d.pulses = PULSES_NONE;
            if (q.pstate != PWR_OPER) begin
               d.pstate = PWR_OPER;
               d.stale = 1'b1;
            end
         end
      end else if (strobe_rise) begin
         d.pulses = pulse_next;
         if (pulse_next == PULSES_TO_NAP) begin
            d.pstate = PWR_NAP;
         end else if (pulse_next == PULSES_TO_SLEEP) begin
            d.pstate = PWR_SLEEP;
         end else if (pulse_next == PULSES_TO_WAKE) begin
            // Count restarts so pulses alone go round again
            d.pstate = PWR_OPER;
            d.pulses = PULSES_NONE;
            d.stale = 1'b1;
         end
      end

      // Conversion start: previous result goes out, new one is held
      // Limitation: a fall mid-readout cuts the word short,
      // so the host must give all sixteen falls first
      if (conv_start) begin
         d.shift1 = q.held1;
         d.shift2 = q.held2;
         d.out_stale = q.stale;
         d.stale = 1'b0;
         d.bits_left = BITS_PER_RESULT;
         if (fifo_valid) begin
            d.held1 = fifo_word[2*WORD_BITS-1:WORD_BITS];
            d.held2 = fifo_word[WORD_BITS-1:0];
         end
      end else if (sck_fall && q.bits_left != BITS_NONE) begin
         // Both lanes step together on the same edge
         d.shift1 = shift_up(q.shift1);
         d.shift2 = shift_up(q.shift2);
         d.bits_left = q.bits_left - BIT_STEP;
      end

      // Echo follows the clock in the cycle the data moves
      // Idle echo rests low: no capture edge between words
      d.echo = (q.bits_left != BITS_NONE) ? sck_level : 1'b0;
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // Reset marks the first result stale, as a wake from nap or sleep does
   // Only constants load here, the stale preset included
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.stale <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // CMOS holds negative legs low, as the pad pull-downs would
   // Lanes and echo leave flops on one edge: skew matched
   assign channel_one_serial_out_p = q.shift1[WORD_BITS-1];
   assign channel_two_serial_out_p = q.shift2[WORD_BITS-1];
   assign channel_one_serial_out_n = lvds & ~q.shift1[WORD_BITS-1];
   assign channel_two_serial_out_n = lvds & ~q.shift2[WORD_BITS-1];
   assign echoed_capture_clock_p = q.echo & ~echo_off;
   assign echoed_capture_clock_n = lvds & ~q.echo;
   assign nap_active = (q.pstate == PWR_NAP);
   assign sleep_active = (q.pstate == PWR_SLEEP);
   assign result_stale = q.out_stale;
   assign readout_busy = (q.bits_left != BITS_NONE);

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Properties watch decoded edges, not the pins

   // Second strobe rise with a quiet clock
   sequence s_second_rise;
      q.pstate == PWR_OPER && strobe_rise && !sck_rise && q.pulses == PULSE_STEP;
   endsequence

   // Fourth rise overall while napping
   sequence s_fourth_rise;
      q.pstate == PWR_NAP && strobe_rise && !sck_rise && pulse_next == PULSES_TO_SLEEP;
   endsequence

   // Fifth rise while sleeping
   sequence s_fifth_rise;
      q.pstate == PWR_SLEEP && strobe_rise && !sck_rise && pulse_next == PULSES_TO_WAKE;
   endsequence

   a_conv_load: assert property (
      conv_start |=> q.bits_left == BITS_PER_RESULT && q.shift1 == $past(q.held1))
      else $error("Conversion start did not load the readout");

   a_shift_msb: assert property (
      (sck_fall && !conv_start && readout_busy)
      |=> q.shift1 == shift_up($past(q.shift1)) && q.bits_left == $past(q.bits_left) - BIT_STEP)
      else $error("Serial clock fall did not shift the result");

   a_nap_entry: assert property (
      s_second_rise |=> nap_active && q.pulses == PULSES_TO_NAP)
      else $error("Second strobe rise did not enter nap");

   a_nap_wake: assert property (
      (q.pstate == PWR_NAP && sck_rise) |=> q.pstate == PWR_OPER && q.pulses == PULSES_NONE)
      else $error("Clock rise did not end nap");

   a_sleep_entry: assert property (
      s_fourth_rise |=> sleep_active)
      else $error("Two more pulses did not enter sleep");

   a_sleep_wake_clk: assert property (
      (q.pstate == PWR_SLEEP && sck_rise && !lvds) |=> q.pstate == PWR_OPER && q.stale)
      else $error("CMOS clock rise did not end sleep");

   a_fifth_wake: assert property (
      s_fifth_rise |=> q.pstate == PWR_OPER && q.pulses == PULSES_NONE)
      else $error("Fifth strobe rise did not end sleep");

   // A strobe fall in nap or sleep leaves a readout in progress untouched
   a_no_conv_idle: assert property (
      (strobe_fall && q.pstate != PWR_OPER && !sck_fall) |=> q.bits_left == $past(q.bits_left))
      else $error("Conversion started outside operation");

   a_echo_tied: assert property (
      (q.tie_s[1] && !lvds) |-> !echoed_capture_clock_p)
      else $error("Echo clock driven while disabled");

   a_cmos_legs: assert property (
      !lvds |-> !channel_one_serial_out_n && !channel_two_serial_out_n && !echoed_capture_clock_n)
      else $error("Negative leg driven in CMOS mode");

   // Echo tracks the decoded clock while bits remain
   a_echo_match: assert property (
      (readout_busy && !conv_start) |=> q.echo == $past(sck_level))
      else $error("Echo clock does not follow serial clock");

   // LVDS sleep ignores clock rises, count kept
   a_lvds_sleep: assert property (
      (q.pstate == PWR_SLEEP && sck_rise && lvds)
      |=> sleep_active && q.pulses == $past(q.pulses))
      else $error("Clock rise changed LVDS sleep");

   // Clock activity restarts the strobe count, except in LVDS sleep
   a_clock_keeps: assert property (
      (sck_rise && !(q.pstate == PWR_SLEEP && lvds)) |=> q.pulses == PULSES_NONE)
      else $error("Clock rise kept the strobe count");

   // The fifth rise clears, so the count stays low
   a_pulse_cap: assert property (
      q.pulses <= PULSES_TO_SLEEP)
      else $error("Strobe count out of range");

   // Conversion start takes the oldest pair
   a_result_pop: assert property (
      (conv_start && fifo_valid) |=> {q.held1, q.held2} == $past(fifo_word))
      else $error("Buffered pair not taken");

   // Stale mark moves to the word shifted out
   a_stale_mark: assert property (
      conv_start |=> result_stale == $past(q.stale))
      else $error("Stale mark not passed on");

endmodule : adc_serial_readout

// ==== test/host_model.sv ====
// Host-side model: strobes conversions, clocks both lanes out and captures them
`timescale 1ns/1ps
module host_model (
   // Clock and interface mode
   clk_sys,
   lvds_select,
   // Pins driven towards the block
   convert_strobe,
   serial_clk_p,
   serial_clk_n,
   // Lanes and echoed clock from the block
   lane1_p,
   lane1_n,
   lane2_p,
   lane2_n,
   echo_p,
   echo_n,
   // Block status, judged during the first bit
   result_stale_tap,
   busy_tap
);
   input wire logic clk_sys;
   input wire logic lvds_select;
   output logic convert_strobe;
   output logic serial_clk_p;
   output logic serial_clk_n;
   input wire logic lane1_p;
   input wire logic lane1_n;
   input wire logic lane2_p;
   input wire logic lane2_n;
   input wire logic echo_p;
   input wire logic echo_n;
   input wire logic result_stale_tap;
   input wire logic busy_tap;

   // Negative clock leg: complement in LVDS, pulled down when unused in CMOS
   assign serial_clk_n = lvds_select ? ~serial_clk_p : 1'b0;

   // Both pins idle low; the serial clock stands still outside frames
   initial begin
      convert_strobe = 1'b0;
      serial_clk_p = 1'b0;
   end

   // ----------------------------------------------------------------------
   // Host actions
   // ----------------------------------------------------------------------
   // One strobe pulse with the serial clock held static
   task automatic strobe_pulse();
      @(posedge clk_sys);
      convert_strobe <= 1'b1; // (stretched so the synchroniser sees it)
      repeat (4) @(posedge clk_sys);
      convert_strobe <= 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask : strobe_pulse

   // A single serial clock rising edge, used to wake the block
   task automatic wake_clock();
      @(posedge clk_sys);
      serial_clk_p <= 1'b1;
      repeat (4) @(posedge clk_sys);
      serial_clk_p <= 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask : wake_clock

   // Sixteen clock cycles of 200 ns; bits taken at the end of each high phase.
   // The rate is far below full throughput because the block oversamples it.
   task automatic clock_bits(output logic [15:0] d1, output logic [15:0] d2,
                             output logic [15:0] n1, output logic [15:0] n2,
                             output logic stale, output logic busy,
                             output logic eh_p, output logic eh_n, output logic el_p);
      d1 = '0;
      d2 = '0;
      n1 = '0;
      n2 = '0;
      eh_p = 1'b1;
      eh_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         serial_clk_p <= 1'b1; // (clock activity keeps it awake)
         repeat (4) @(posedge clk_sys);
         d1 = {d1[14:0], lane1_p};
         d2 = {d2[14:0], lane2_p};
         n1 = {n1[14:0], lane1_n};
         n2 = {n2[14:0], lane2_n};
         // Status is judged while the first bit stands
         if (i == 0) begin
            stale = result_stale_tap;
            busy = busy_tap;
         end
         serial_clk_p <= 1'b0;
         repeat (2) @(posedge clk_sys);
         // The echo lags the pin by the synchroniser, so look mid low phase
         eh_p = eh_p & echo_p;
         eh_n = eh_n | echo_n;
         repeat (2) @(posedge clk_sys);
      end
      repeat (4) @(posedge clk_sys);
      el_p = echo_p;
   endtask : clock_bits
endmodule : host_model

// ==== test/adc_serial_readout_tb.sv ====
// Self-checking bench for the converter readout, power states and FIFO
`timescale 1ns/1ps
module adc_serial_readout_tb;
   import adc_readout_pkg::*;

   logic clk_sys = 1'b0;  // 40 MHz system clock
   logic rst_n;           // Active-low reset
   logic lvds_select;     // Interface mode pin
   logic echo_n_tied;     // Echo disable strap
   logic [15:0] sample_ch1, sample_ch2;
   logic sample_valid;
   wire logic convert_strobe, serial_clk_p, serial_clk_n, sample_ready;
   wire logic l1p, l1n, l2p, l2n, ecp, ecn;
   wire logic nap_active, sleep_active, result_stale, readout_busy;
   int n_mismatch = 0;  // Mismatches seen
   int n_tests = 0;     // Comparisons made
   logic last_stale;  // Stale flag seen during the latest burst

   always #12.5 clk_sys = ~clk_sys;

   adc_serial_readout i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .convert_strobe(convert_strobe), .serial_clk_p(serial_clk_p),
      .serial_clk_n(serial_clk_n), .lvds_select(lvds_select), .echo_n_tied(echo_n_tied),
      .sample_ch1(sample_ch1), .sample_ch2(sample_ch2), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .channel_one_serial_out_p(l1p),
      .channel_one_serial_out_n(l1n), .channel_two_serial_out_p(l2p),
      .channel_two_serial_out_n(l2n), .echoed_capture_clock_p(ecp),
      .echoed_capture_clock_n(ecn), .nap_active(nap_active), .sleep_active(sleep_active),
      .result_stale(result_stale), .readout_busy(readout_busy));

   host_model i_host (.clk_sys(clk_sys), .lvds_select(lvds_select),
      .convert_strobe(convert_strobe), .serial_clk_p(serial_clk_p),
      .serial_clk_n(serial_clk_n), .lane1_p(l1p), .lane1_n(l1n), .lane2_p(l2p),
      .lane2_n(l2n), .echo_p(ecp), .echo_n(ecn), .result_stale_tap(result_stale),
      .busy_tap(readout_busy));

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Compare one value and count it
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Distinct test words that exercise both ends of the lane
   function automatic logic [15:0] word(input int i);
      return 16'h0123 + 16'h1111 * 16'(i);
   endfunction : word

   // Offer one result pair and wait until the FIFO takes it
   task automatic push(input logic [15:0] a);
      int k;
      sample_ch1 <= a;
      sample_ch2 <= ~a;
      sample_valid <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (sample_ready !== 1'b1 && k < 50);
   endtask : push

   // One conversion and readout with lane, echo and status checks
   task automatic burst(input logic [15:0] e1, input logic [15:0] e2, input logic lvds,
                        input logic eon, input logic chk, input int idle);
      logic [15:0] d1, d2, n1, n2;
      logic stl, bsy, ehp, ehn, elp;
      i_host.strobe_pulse();
      if (idle > 0) begin
         repeat (idle) @(posedge clk_sys);
         check("busy_idle", 16'(readout_busy), 16'h0001);
      end
      i_host.clock_bits(d1, d2, n1, n2, stl, bsy, ehp, ehn, elp);
      if (chk) begin
         check("lane1", d1, e1);
         check("lane2", d2, e2);
      end
      check("lane1_n", n1, lvds ? ~d1 : 16'h0000);
      check("lane2_n", n2, lvds ? ~d2 : 16'h0000);
      check("echo_high", 16'(ehp), 16'(eon));
      check("echo_n_high", 16'(ehn), 16'h0000);
      check("echo_low", 16'(elp), 16'h0000);
      check("busy_first", 16'(bsy), 16'h0001);
      check("busy_end", 16'(readout_busy), 16'h0000);
      last_stale = stl;
   endtask : burst

   // Power state as {sleep, nap}
   task automatic power(input logic [1:0] exp);
      check("power", {14'h0000, sleep_active, nap_active}, {14'h0000, exp});
   endtask : power

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Fill the FIFO until it refuses, then drain it with one-latency readout
   task automatic t_fill_drain();
      check("ready_idle", 16'(sample_ready), 16'h0001);
      for (int i = 0; i < 16; i++) push(word(i));
      sample_ch1 <= 16'hFFFF;
      repeat (3) @(posedge clk_sys);
      check("ready_full", 16'(sample_ready), 16'h0000);
      sample_valid <= 1'b0;
      for (int k = 1; k <= 18; k++) begin
         // First word after reset is zero; an empty FIFO repeats the last word
         if (k == 1) begin
            burst(16'h0000, 16'h0000, 1'b0, 1'b1, 1'b1, 40);
         end else begin
            burst(word(k > 17 ? 15 : k - 2), ~word(k > 17 ? 15 : k - 2), 1'b0, 1'b1, 1'b1, 0);
         end
         check("stale", 16'(last_stale), 16'(k == 1));
      end
      check("ready_drained", 16'(sample_ready), 16'h0001);
   endtask : t_fill_drain

   // Strobe pulses alone step operate, nap, sleep, operate; clock rises wake
   task automatic t_power_cmos();
      logic [1:0] tbl [5] = '{2'b00, 2'b01, 2'b01, 2'b10, 2'b00};
      for (int i = 0; i < 5; i++) begin
         i_host.strobe_pulse();
         power(tbl[i]);
      end
      repeat (2) i_host.strobe_pulse();
      power(2'b01);
      i_host.wake_clock();
      power(2'b00);
      repeat (4) i_host.strobe_pulse();
      power(2'b10);
      i_host.wake_clock();
      power(2'b00);
      burst(16'h0000, 16'h0000, 1'b0, 1'b1, 1'b0, 0); // data not relied on
      check("stale_wake", 16'(last_stale), 16'h0001);
   endtask : t_power_cmos

   // Differential lanes, and a clock rise that must not end LVDS sleep
   task automatic t_lvds();
      lvds_select <= 1'b1;
      repeat (4) @(posedge clk_sys);
      burst(word(15), ~word(15), 1'b1, 1'b1, 1'b1, 0);
      repeat (4) i_host.strobe_pulse();
      power(2'b10);
      i_host.wake_clock();
      power(2'b10);
      i_host.strobe_pulse();
      power(2'b00);
      lvds_select <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask : t_lvds

   // Tied negative echo leg silences the positive echo in CMOS
   task automatic t_echo_tied();
      echo_n_tied <= 1'b1;
      repeat (4) @(posedge clk_sys);
      burst(word(15), ~word(15), 1'b0, 1'b0, 1'b1, 0);
      echo_n_tied <= 1'b0;
   endtask : t_echo_tied

   // Print the counts and the verdict, then stop
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   // Main sequence: reset for three cycles, then every scenario in turn
   initial begin
      rst_n = 1'b0;
      lvds_select = 1'b0;
      echo_n_tied = 1'b0;
      sample_ch1 = '0;
      sample_ch2 = '0;
      sample_valid = 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys); // settling wait scaled down
      t_fill_drain();
      t_power_cmos();
      t_lvds();
      t_echo_tied();
      end_of_test();
   end

   // Watchdog, well beyond the roughly 3300 cycles the scenarios need
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_mismatch++;
      $display("Watchdog expired");
      end_of_test();
   end
endmodule : adc_serial_readout_tb
